// file: pkg/pdc_pkg.sv
// Purpose: Shared constants for the duty cycle comparison block
// Assumes: 32-bit AXI4-Lite register access, one aligned word per register
// Notes:   Offsets are byte addresses; fields sit in the low bits of each word
package pdc_pkg;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CONTROL = 8'h00;
   localparam logic [7:0] OFS_PERIOD = 8'h04;
   localparam logic [7:0] OFS_COUNTER = 8'h08;
   localparam logic [7:0] OFS_DUTY_BASE = 8'h10;
   localparam logic [7:0] OFS_DUTY_STEP = 8'h04;

   // ----------------------------------------------------------------
   // Field positions in the time base control and counter words
   // ----------------------------------------------------------------
   localparam int CTL_ENABLE_BIT = 15;
   localparam int CTL_IUE_BIT = 8;
   localparam int CTL_PRESCALE_LSB = 2;
   localparam int CTL_MODE_LSB = 0;
   localparam int CNT_DIR_BIT = 15;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [14:0] PERIOD_RESET = 15'h0000;
   localparam logic [15:0] DUTY_RESET = 16'h0000;

   // ----------------------------------------------------------------
   // AXI responses
   // ----------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------------------------------
   // Time base modes and prescale selections
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_FREE = 2'b00,
      MODE_SINGLE = 2'b01,
      MODE_UPDOWN = 2'b10,
      MODE_DOUBLE = 2'b11
   } pdc_mode_t;

   typedef enum logic [1:0] {
      PRE_1 = 2'b00,
      PRE_4 = 2'b01,
      PRE_16 = 2'b10,
      PRE_64 = 2'b11
   } pdc_pre_t;

   // Last prescaler count per selection
   localparam logic [5:0] PRE_LAST_4 = 6'h03;
   localparam logic [5:0] PRE_LAST_16 = 6'h0F;
   localparam logic [5:0] PRE_LAST_64 = 6'h3F;

endpackage

// file: design/pdc_duty_compare.sv
// Purpose: Four-generator duty cycle comparison unit with its time base
// Assumes: core_clk is the instruction clock; AXI4-Lite master keeps the protocol
// Notes:   Half-cycle edge at 1:1 prescale is flagged on halfEdge for the output stage
//
// Function
// - Four generators, each with a 16-bit writable duty buffer register.
// - Duty bits 15:1 match counter; duty bit 0 picks full or half edge.
// - At prescale 1:4, 1:16, 1:64 duty bit 0 compares with prescaler MSB.
// - Free running mode gives edge aligned outputs from period and duty.
// - Edge aligned: nonzero duty output goes active at counter zero.
// - Edge aligned: output goes inactive when counter equals duty.
// - Zero duty keeps output inactive all period, both alignments.
// - Duty above period keeps output active all period, both alignments.
// - Immediate update set: duty write loads active compare at once.
// - Single event: outputs go active when software sets enable.
// - Single event: output goes inactive on duty match.
// - Single event period match clears counter, outputs, enable; raises event.
// - Single event mode produces edge aligned pulses only.
// - Mode field upper bit set gives center aligned outputs.
// - Center aligned: output goes active on match while counting down.
// - Center aligned: output goes inactive on match while counting up.
// - Hidden active duty register loads from buffer at update points; immediate-update or halted duty writes load it at once.
// - Free running and single event: reload at period match counter reset.
// - Time base disabled: duty write updates active duty immediately.
// - Up/down mode: reload when counter at zero turns upward.
// - Double update mode: reload at zero and at period match.
// - Mode field: 00 free, 01 single, 10 up/down, 11 double update.
// - Up/down counts to period then down; counter bit 15 reads direction.
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
`timescale 1ns/1ns

module pdc_duty_compare #(
   parameter int NUM_GEN = 4,
   parameter int DUTY_W = 16
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // AXI4-Lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Compare outputs toward dead time logic
   output logic [NUM_GEN-1:0] cmpOut,
   output logic [NUM_GEN-1:0] halfEdge,
   output logic periodEvent
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic awHeld;
   logic wHeld;
   logic [7:0] wrAddr;
   logic [31:0] wrData;
   logic [3:0] wrStrb;
   logic wrFire;
   logic tbEnable;
   logic immUpdate;
   pdc_pkg::pdc_mode_t tbMode;
   pdc_pkg::pdc_pre_t tbPre;
   logic [14:0] periodBuf;
   logic [14:0] periodAct;
   logic [14:0] count;
   logic countDown;
   logic [5:0] preCnt;
   logic [5:0] preLast;
   logic preMsb;
   logic tick;
   logic wrControl;
   logic wrPeriod;
   logic perMatch;
   logic zeroTurn;
   logic dutyLoad;
   logic [15:0] dutyBuf [NUM_GEN];
   logic [15:0] dutyAct [NUM_GEN];
   logic [31:0] next_rdata;
   logic next_rerr;

   // Byte-lane merge of a write into a 16-bit register
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                           input logic [3:0] strb);
      logic [15:0] res;
      res = old;
      if (strb[0]) begin
         res[7:0] = data[7:0];
      end
      if (strb[1]) begin
         res[15:8] = data[15:8];
      end
      return res;
   endfunction

   // ----------------------------------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------------------------------
   // Address and data may arrive in either order; both are held until the response
   assign s_axi_awready = !awHeld && !s_axi_bvalid;
   assign s_axi_wready = !wHeld && !s_axi_bvalid;
   assign wrFire = awHeld && wHeld && !s_axi_bvalid;

   // Capture of address and data
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         wrAddr <= 8'h00;
         wrData <= 32'h0000_0000;
         wrStrb <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld <= 1'b1;
            wrAddr <= s_axi_awaddr;
         end else if (wrFire) begin
            awHeld <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld <= 1'b1;
            wrData <= s_axi_wdata;
            wrStrb <= s_axi_wstrb;
         end else if (wrFire) begin
            wHeld <= 1'b0;
         end
      end
   end

   // Write response; unmapped or read-only targets answer SLVERR
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= pdc_pkg::RESP_OKAY;
      end else if (wrFire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (wrControl || wrPeriod || (wrAddr >= pdc_pkg::OFS_DUTY_BASE &&
                         wrAddr < pdc_pkg::OFS_DUTY_BASE + 8'(NUM_GEN * 4) && wrAddr[1:0] == 2'b00))
                        ? pdc_pkg::RESP_OKAY : pdc_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   assign wrControl = wrFire && wrAddr == pdc_pkg::OFS_CONTROL;
   assign wrPeriod = wrFire && wrAddr == pdc_pkg::OFS_PERIOD;

   // ----------------------------------------------------------------
   // Time base control register
   // ----------------------------------------------------------------
   // Hardware halt in single event mode; a software write in the same cycle wins
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tbEnable <= 1'b0;
         immUpdate <= 1'b0;
         tbMode <= pdc_pkg::MODE_FREE;
         tbPre <= pdc_pkg::PRE_1;
      end else begin
         if (perMatch && tbMode == pdc_pkg::MODE_SINGLE) begin
            tbEnable <= 1'b0;
         end
         if (wrControl && wrStrb[1]) begin
            tbEnable <= wrData[pdc_pkg::CTL_ENABLE_BIT];
            immUpdate <= wrData[pdc_pkg::CTL_IUE_BIT];
         end
         if (wrControl && wrStrb[0]) begin
            tbMode <= pdc_pkg::pdc_mode_t'(wrData[pdc_pkg::CTL_MODE_LSB +: 2]);
            tbPre <= pdc_pkg::pdc_pre_t'(wrData[pdc_pkg::CTL_PRESCALE_LSB +: 2]);
         end
      end
   end

   // ----------------------------------------------------------------
   // Prescaler
   // ----------------------------------------------------------------
   // Last count and MSB per selection
   always_comb begin
      case (tbPre)
         pdc_pkg::PRE_4: begin
            preLast = pdc_pkg::PRE_LAST_4;
            preMsb = preCnt[1];
         end
         pdc_pkg::PRE_16: begin
            preLast = pdc_pkg::PRE_LAST_16;
            preMsb = preCnt[3];
         end
         pdc_pkg::PRE_64: begin
            preLast = pdc_pkg::PRE_LAST_64;
            preMsb = preCnt[5];
         end
         default: begin
            preLast = 6'h00;
            preMsb = 1'b0;
         end
      endcase
   end

   assign tick = tbEnable && preCnt == preLast;

   // Prescaler count; a control write restarts it
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         preCnt <= 6'h00;
      end else if (wrControl || !tbEnable || tick) begin
         preCnt <= 6'h00;
      end else begin
         preCnt <= preCnt + 6'h01;
      end
   end

   // ----------------------------------------------------------------
   // Time base counter and direction
   // ----------------------------------------------------------------
   assign perMatch = tick && !countDown && count >= periodAct;
   assign zeroTurn = tick && countDown && count == 15'h0000;

   // Counter: wrap in free and single modes, reverse in up/down modes
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         count <= 15'h0000;
         countDown <= 1'b0;
      end else if (tick) begin
         case (tbMode)
            pdc_pkg::MODE_FREE, pdc_pkg::MODE_SINGLE: begin
               countDown <= 1'b0;
               count <= perMatch ? 15'h0000 : count + 15'h0001;
            end
            pdc_pkg::MODE_UPDOWN, pdc_pkg::MODE_DOUBLE: begin
               if (perMatch) begin
                  countDown <= 1'b1;
                  count <= (count == 15'h0000) ? 15'h0000 : count - 15'h0001;
               end else if (zeroTurn) begin
                  countDown <= 1'b0;
                  count <= (periodAct == 15'h0000) ? 15'h0000 : 15'h0001;
               end else if (countDown) begin
                  count <= count - 15'h0001;
               end else begin
                  count <= count + 15'h0001;
               end
            end
            default: begin
               count <= count;
            end
         endcase
      end
   end

   // Period buffer and its hidden active copy, loaded at zero or while halted
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         periodBuf <= pdc_pkg::PERIOD_RESET;
         periodAct <= pdc_pkg::PERIOD_RESET;
      end else begin
         if (wrPeriod) begin
            periodBuf <= 15'(merge16({1'b0, periodBuf}, wrData, wrStrb));
         end
         if (!tbEnable || (tbMode[1] ? zeroTurn : perMatch)) begin
            periodAct <= periodBuf;
         end
      end
   end

   // ----------------------------------------------------------------
   // Duty update points
   // ----------------------------------------------------------------
   // Reload points depend on mode; apart from immediate-update or halted duty writes, only these edges load
   always_comb begin
      case (tbMode)
         pdc_pkg::MODE_FREE, pdc_pkg::MODE_SINGLE: dutyLoad = perMatch;
         pdc_pkg::MODE_UPDOWN: dutyLoad = zeroTurn;
         pdc_pkg::MODE_DOUBLE: dutyLoad = zeroTurn || perMatch;
         default: dutyLoad = 1'b0;
      endcase
   end

   // Period event pulse, one cycle per update point
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         periodEvent <= 1'b0;
      end else begin
         periodEvent <= dutyLoad;
      end
   end

   // ----------------------------------------------------------------
   // Generators
   // ----------------------------------------------------------------
   for (genvar g = 0; g < NUM_GEN; g++) begin : gen_unit
      logic wrDuty;
      logic [15:0] newBuf;

      assign wrDuty = wrFire && wrAddr == pdc_pkg::OFS_DUTY_BASE + 8'(g * 4);
      assign newBuf = merge16(dutyBuf[g], wrData, wrStrb);

      // Buffer and hidden active duty register
      always_ff @(posedge core_clk or negedge rst_n) begin
         if (!rst_n) begin
            dutyBuf[g] <= pdc_pkg::DUTY_RESET;
            dutyAct[g] <= pdc_pkg::DUTY_RESET;
         end else begin
            if (wrDuty) begin
               dutyBuf[g] <= newBuf;
            end
            if (wrDuty && (immUpdate || !tbEnable)) begin
               dutyAct[g] <= newBuf;
            end else if (dutyLoad) begin
               dutyAct[g] <= wrDuty ? newBuf : dutyBuf[g];
            end
         end
      end

      // Level compare of {counter, half step} against duty:
      // edge mode rises at zero, falls on match; center mode
      // rises on down match, falls on up match. Zero duty never
      // wins, duty above the period always does; halted is low.
      always_ff @(posedge core_clk or negedge rst_n) begin
         if (!rst_n) begin
            cmpOut[g] <= 1'b0;
            halfEdge[g] <= 1'b0;
         end else begin
            cmpOut[g] <= tbEnable && !(perMatch && tbMode == pdc_pkg::MODE_SINGLE) &&
                         ({count, preMsb} < dutyAct[g]);
            halfEdge[g] <= tbPre == pdc_pkg::PRE_1 && dutyAct[g][0];
         end
      end
   end

   // ----------------------------------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------------------------------
   assign s_axi_arready = !s_axi_rvalid;

   // Read decode
   always_comb begin
      next_rdata = 32'h0000_0000;
      next_rerr = 1'b0;
      case (s_axi_araddr)
         pdc_pkg::OFS_CONTROL: begin
            next_rdata[pdc_pkg::CTL_ENABLE_BIT] = tbEnable;
            next_rdata[pdc_pkg::CTL_IUE_BIT] = immUpdate;
            next_rdata[pdc_pkg::CTL_PRESCALE_LSB +: 2] = tbPre;
            next_rdata[pdc_pkg::CTL_MODE_LSB +: 2] = tbMode;
         end
         pdc_pkg::OFS_PERIOD: begin
            next_rdata[14:0] = periodBuf;
         end
         pdc_pkg::OFS_COUNTER: begin
            next_rdata[pdc_pkg::CNT_DIR_BIT] = countDown;
            next_rdata[14:0] = count;
         end
         default: begin
            next_rerr = 1'b1;
            for (int i = 0; i < NUM_GEN; i++) begin
               if (s_axi_araddr == pdc_pkg::OFS_DUTY_BASE + 8'(i * 4)) begin
                  next_rdata[15:0] = dutyBuf[i];
                  next_rerr = 1'b0;
               end
            end
         end
      endcase
   end

   // Read data register, answer one cycle after the address is taken
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= pdc_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rerr ? pdc_pkg::RESP_SLVERR : pdc_pkg::RESP_OKAY;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule // pdc_duty_compare

// file: tb/pdc_output_stage_model.sv
// Purpose: Behavioural output stage tally seen from the compare side
// Assumes: Compare outputs are settled levels sampled on core_clk
// Notes:   Only tallies active cycles; no pin drive is modelled
`timescale 1ns/1ns

module pdc_output_stage_model #(
   parameter int NUM_GEN = 4
) (
   // Clock, reset and window control
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clearCounts,
   // Raw compare levels
   input wire logic [NUM_GEN-1:0] cmpOut,
   // Active cycles per generator
   output logic [NUM_GEN-1:0][15:0] highCount
);
   // Tally active cycles; phase free over whole periods
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         highCount <= '0;
      end else if (clearCounts) begin
         highCount <= '0;
      end else begin
         for (int g = 0; g < NUM_GEN; g++) begin
            highCount[g] <= highCount[g] + 16'(cmpOut[g]);
         end
      end
   end
endmodule // pdc_output_stage_model

// file: tb/pdc_duty_compare_sva.sv
// Purpose: Port level checks of the duty compare block
// Assumes: Write address and data are offered together
// Notes:   Mode shadow follows software writes only
`timescale 1ns/1ns

module pdc_duty_compare_sva #(
   parameter int NUM_GEN = 4
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Register bus
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Compare side
   input wire logic [NUM_GEN-1:0] cmpOut,
   input wire logic periodEvent
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   logic wrTake;
   logic ctlWr;
   logic [1:0] mode;
   // Write taken on both channels in one edge
   assign wrTake = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   assign ctlWr = wrTake && (s_axi_awaddr == pdc_pkg::OFS_CONTROL);

   // Mode shadow; hardware never alters the mode field
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mode <= 2'h0;
      end else if (ctlWr) begin
         mode <= s_axi_wdata[1:0];
      end
   end

   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped early");
   AST_AW_BUSY: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   AST_AR_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while data pending");
   AST_WR_RESP: assert property (wrTake |-> ##2 s_axi_bvalid)
      else $error("write response late");
   AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   AST_CNT_RO: assert property (wrTake && s_axi_awaddr == pdc_pkg::OFS_COUNTER |-> ##2
      s_axi_bresp == pdc_pkg::RESP_SLVERR) else $error("counter write not refused");
   AST_RD_ERR: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h20 |=>
      s_axi_rresp == pdc_pkg::RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read wrong");
   AST_OFF_OUT: assert property (ctlWr && !s_axi_wdata[15] |-> ##3 (cmpOut == '0) [*3])
      else $error("output active with time base off");
   AST_SINGLE_STOP: assert property (mode == pdc_pkg::MODE_SINGLE && periodEvent |->
      cmpOut == '0 ##1 (cmpOut == '0) [*2]) else $error("single event did not halt outputs");
endmodule // pdc_duty_compare_sva

bind pdc_duty_compare pdc_duty_compare_sva #(.NUM_GEN(NUM_GEN)) u_sva (
   .core_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
   .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmpOut, .periodEvent
);

// file: tb/pdc_duty_compare_test.sv
// Purpose: Register and waveform tests of the duty compare block
// Assumes: Bus signals change just after a rising edge
// Notes:   Windows span whole periods so counts do not depend on phase
`timescale 1ns/1ns

module pdc_duty_compare_test;
   logic core_clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, periodEvent, clearCounts;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb, cmpOut, halfEdge;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [3:0][15:0] highCount, dv;
   int n_errors, n_compared, nEv, len;

   pdc_duty_compare uut (.core_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cmpOut,
      .halfEdge, .periodEvent);
   pdc_output_stage_model stage (.core_clk, .rst_n, .clearCounts, .cmpOut, .highCount);

   // Free running 20 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic stop_test();
      $display("compared %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic give_up();
      n_errors++;
      $display("mismatch at %0t: no bus response", $time);
      stop_test();
   endtask

   function automatic logic [7:0] dutyAddr(input int g);
      return pdc_pkg::OFS_DUTY_BASE + 8'(g) * pdc_pkg::OFS_DUTY_STEP;
   endfunction

   // Sample at the falling edge, release just after the rising edge
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ta;
      logic tw;
      logic tb;
      logic [1:0] r;
      tb = 1'b0;
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      for (int i = 0; i < 40 && !tb; i++) begin
         @(negedge core_clk);
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         tb = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge core_clk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
      end
      if (!tb) give_up();
      check(32'(r), 32'(er));
   endtask

   task automatic rd_check(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      logic ta;
      logic tr;
      logic [31:0] d;
      logic [1:0] r;
      tr = 1'b0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      for (int i = 0; i < 40 && !tr; i++) begin
         @(negedge core_clk);
         ta = s_axi_arvalid && s_axi_arready;
         tr = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge core_clk);
         if (ta) s_axi_arvalid <= 1'b0;
      end
      if (!tr) give_up();
      check(d, ed);
      check(32'(r), 32'(er));
   endtask

   task automatic set_duties(input logic [3:0][15:0] v);
      for (int g = 0; g < 4; g++) axi_write(dutyAddr(g), 32'(v[g]), pdc_pkg::RESP_OKAY);
   endtask

   // Count period events over n cycles
   task automatic run(input int n);
      repeat (n) begin
         @(negedge core_clk);
         if (periodEvent === 1'b1) nEv++;
         @(posedge core_clk);
      end
   endtask

   task automatic clr();
      clearCounts <= 1'b1;
      @(posedge core_clk);
      clearCounts <= 1'b0;
      nEv = 0;
   endtask

   task automatic expect_win(input logic [3:0][15:0] e, input int ev, input logic [3:0] eh);
      @(negedge core_clk);
      for (int g = 0; g < 4; g++) check(32'(highCount[g]), 32'(e[g]));
      check(32'(nEv), 32'(ev));
      check(32'(halfEdge), 32'(eh));
      @(posedge core_clk);
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      n_errors = 0;
      n_compared = 0;
      nEv = 0;
      rst_n = 1'b0;
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
      {s_axi_araddr, s_axi_arvalid, clearCounts} = '0;
      {s_axi_wstrb, s_axi_bready, s_axi_rready} = 6'h0F;
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      // Reset values, read back, refused places
      rd_check(dutyAddr(2), 32'h0, pdc_pkg::RESP_OKAY);
      dv = {16'hF00D, 16'h8001, 16'h7FFE, 16'h1234};
      set_duties(dv);
      for (int g = 0; g < 4; g++) rd_check(dutyAddr(g), 32'(dv[g]), pdc_pkg::RESP_OKAY);
      axi_write(pdc_pkg::OFS_COUNTER, 32'h5, pdc_pkg::RESP_SLVERR);
      axi_write(8'h40, 32'h1, pdc_pkg::RESP_SLVERR);
      rd_check(8'h40, 32'h0, pdc_pkg::RESP_SLVERR);
      $display("registers done");
      // Single event: zero, short, full and over-period duties
      axi_write(pdc_pkg::OFS_PERIOD, 32'h4, pdc_pkg::RESP_OKAY);
      set_duties({16'h000B, 16'h0008, 16'h0003, 16'h0000});
      clr();
      axi_write(pdc_pkg::OFS_CONTROL, 32'h8001, pdc_pkg::RESP_OKAY);
      run(20);
      expect_win({16'd4, 16'd4, 16'd2, 16'd0}, 1, 4'hA);
      rd_check(pdc_pkg::OFS_CONTROL, 32'h1, pdc_pkg::RESP_OKAY);
      rd_check(pdc_pkg::OFS_COUNTER, 32'h0, pdc_pkg::RESP_OKAY);
      $display("single event done");
      // Free running edge aligned, then a buffered duty change
      axi_write(pdc_pkg::OFS_CONTROL, 32'h8000, pdc_pkg::RESP_OKAY);
      run(10);
      clr();
      run(10);
      expect_win({16'd10, 16'd8, 16'd4, 16'd0}, 2, 4'hA);
      axi_write(dutyAddr(1), 32'h8, pdc_pkg::RESP_OKAY);
      run(10);
      clr();
      run(10);
      expect_win({16'd10, 16'd8, 16'd8, 16'd0}, 2, 4'h8);
      axi_write(pdc_pkg::OFS_CONTROL, 32'h0, pdc_pkg::RESP_OKAY);
      axi_write(dutyAddr(1), 32'h3, pdc_pkg::RESP_OKAY);
      $display("free running done");
      // Center aligned, single and double update points
      for (int m = 2; m < 4; m++) begin
         axi_write(pdc_pkg::OFS_CONTROL, 32'h8000 | 32'(m), pdc_pkg::RESP_OKAY);
         run(16);
         clr();
         run(16);
         expect_win({16'd16, 16'd14, 16'd6, 16'd0}, m * 2 - 2, 4'hA);
         axi_write(pdc_pkg::OFS_CONTROL, 32'h0, pdc_pkg::RESP_OKAY);
      end
      $display("center aligned done");
      // Prescaled time base, duty bit 0 against prescaler MSB
      axi_write(pdc_pkg::OFS_PERIOD, 32'h1, pdc_pkg::RESP_OKAY);
      axi_write(dutyAddr(3), 32'h1, pdc_pkg::RESP_OKAY);
      for (int p = 1; p < 4; p++) begin
         len = 4 << (2 * (p - 1));
         axi_write(pdc_pkg::OFS_CONTROL, 32'h8000 | 32'(p << 2), pdc_pkg::RESP_OKAY);
         run(4 * len);
         clr();
         run(4 * len);
         expect_win({16'(len), 16'(4 * len), 16'(3 * len), 16'd0}, 2, 4'h0);
         axi_write(pdc_pkg::OFS_CONTROL, 32'h0, pdc_pkg::RESP_OKAY);
      end
      $display("prescaler done");
      stop_test();
   end
endmodule // pdc_duty_compare_test
